// [src/pam_pkg.sv]
// Package with the register map, field positions, reset values and carriers of the pulse accumulator block.
package pam_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;

    // Register indices on the plain register port.
    localparam logic [4:0] OFS_TIMER_PORT_DIRECTION   = 5'h00;
    localparam logic [4:0] OFS_ACCUM_B_CONTROL        = 5'h01;
    localparam logic [4:0] OFS_ACCUM_B_FLAGS          = 5'h02;
    localparam logic [4:0] OFS_ACCUM3_HOLD            = 5'h03;
    localparam logic [4:0] OFS_ACCUM2_HOLD            = 5'h04;
    localparam logic [4:0] OFS_ACCUM1_HOLD            = 5'h05;
    localparam logic [4:0] OFS_ACCUM0_HOLD            = 5'h06;
    localparam logic [4:0] OFS_MODULUS_COUNT          = 5'h07;
    localparam logic [4:0] OFS_CAPTURE0_HOLD          = 5'h08;
    localparam logic [4:0] OFS_CAPTURE3_HOLD          = 5'h0B;
    localparam logic [4:0] OFS_ACCUM_B_HIGH_BYTE      = 5'h0C;
    localparam logic [4:0] OFS_ACCUM_B_LOW_BYTE       = 5'h0D;
    localparam logic [4:0] OFS_TIMER_SYSTEM_CONTROL   = 5'h0E;
    localparam logic [4:0] OFS_MODULUS_CONTROL        = 5'h0F;
    localparam logic [4:0] OFS_CAPTURE_SYSTEM_CONTROL = 5'h10;
    localparam logic [4:0] OFS_SMALL_ACCUM_ENABLE_REG = 5'h11;
    localparam logic [4:0] OFS_ACCUM3_COUNT           = 5'h12;
    localparam logic [4:0] OFS_ACCUM2_COUNT           = 5'h13;

    // Field positions.
    localparam int unsigned BIT_ACCUM_B_ENABLE       = 0;
    localparam int unsigned BIT_ACCUM_B_OVF_IRQ_EN   = 1;
    localparam int unsigned BIT_ACCUM_B_OVF_FLAG     = 1;
    localparam int unsigned BIT_TIMER_GLOBAL_ENABLE  = 7;
    localparam int unsigned BIT_WAIT_HALT            = 6;
    localparam int unsigned BIT_DEBUG_FREEZE         = 5;
    localparam int unsigned BIT_FAST_FLAG_CLEAR      = 4;
    localparam int unsigned BIT_MODULUS_RUN_ENABLE   = 0;
    localparam int unsigned BIT_MODULUS_RELOAD_MODE  = 1;
    localparam int unsigned BIT_READ_LOAD_SELECT     = 2;
    localparam int unsigned BIT_FORCE_LOAD           = 3;
    localparam int unsigned BIT_MODULUS_ZERO_FLAG    = 7;
    localparam int unsigned BIT_LATCH_MODE_SELECT    = 0;
    localparam int unsigned BIT_HOLDING_BUFFER_EN    = 1;
    localparam int unsigned BIT_ACCUM_A_ENABLE       = 2;

    // Reset values and counter constants.
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [7:0]  BYTE_MAX  = 8'hFF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONE  = 16'h0001;

    // Modulus prescaler: one count tick every so many core clocks.
    localparam int unsigned MOD_PRESCALE_CYCLES = 4;

    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pam_req_s;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } pam_unused_s;

endpackage

// [src/pam_port_accum.sv]
// Timer port direction, pulse accumulators, holding registers and modulus down-counter.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps

module pam_port_accum #(
    parameter int unsigned PRESCALE = pam_pkg::MOD_PRESCALE_CYCLES
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic [4:0]              reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [15:0]             reg_rdata,
    input  wire logic [7:0]              pin_in,
    input  wire logic [7:0]              oc_enable,
    input  wire logic [3:0][15:0]        capture_registers,
    input  wire logic                    stop_mode,
    input  wire logic                    debug_mode_state,
    input  wire logic                    wait_mode,
    output logic      [7:0]              pin_oe,
    output logic                         accum_b_irq,
    output logic                         modulus_zero_flag
);

    typedef struct packed {
        logic [7:0]       sync1;
        logic [7:0]       sync2;
        logic [7:0]       sync3;
        logic [7:0]       pin_level;
        logic [7:0]       pin_direction_bits;
        logic             accum_b_enable;
        logic             accum_b_overflow_irq_enable;
        logic             accum_b_overflow_flag;
        logic [3:0][7:0]  accum;
        logic [3:0][7:0]  accum_hold;
        logic [3:0][15:0] capture_hold;
        logic [7:0]       timer_system_control;
        logic             modulus_run_enable;
        logic             modulus_reload_mode;
        logic             read_load_select;
        logic             modulus_zero_flag;
        logic             latch_mode_select;
        logic             holding_buffer_enable;
        logic             accum_a_enable;
        logic [3:0]       small_accum_enable;
        logic [15:0]      mod_count;
        logic [15:0]      mod_load;
        logic [7:0]       prescale;
        logic [15:0]      rdata;
    } pam_state_s;

    localparam logic [7:0] PRESCALE_LAST = 8'(PRESCALE - 1);

    pam_state_s st_q;
    pam_state_s st_d;

    logic [7:0] pin_rise;
    logic       timer_run;
    logic       accum_run;
    logic       mod_tick;
    logic       latch_evt;
    logic       wr_zero_mod;
    logic [3:0] accum_live;
    logic [3:0] accum_inc;
    logic       b_carry;
    logic       a_carry;
    logic       b_wrap;
    logic       b_access;

    always_comb begin
        st_d = st_q;

        // Synchroniser: a change counts once the second and third stages agree.
        st_d.sync1 = pin_in;
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        for (int i = 0; i < 8; i++) begin
            if (st_q.sync2[i] == st_q.sync3[i]) begin
                st_d.pin_level[i] = st_q.sync3[i];
            end
        end
        pin_rise = st_q.sync2 & st_q.sync3 & ~st_q.pin_level;

        // Stop halts the accumulators and the modulus counter; debug and wait halt only the modulus counter, when their bits ask for it.
        accum_run = ~stop_mode;
        timer_run = st_q.timer_system_control[pam_pkg::BIT_TIMER_GLOBAL_ENABLE]
                  & ~stop_mode
                  & ~(debug_mode_state & st_q.timer_system_control[pam_pkg::BIT_DEBUG_FREEZE])
                  & ~(wait_mode & st_q.timer_system_control[pam_pkg::BIT_WAIT_HALT]);

        // Accumulator B ignores the timer enable so it still counts with the timer off.
        accum_live[0] = st_q.accum_b_enable | st_q.small_accum_enable[0];
        accum_live[1] = st_q.accum_b_enable | st_q.small_accum_enable[1];
        accum_live[2] = st_q.accum_a_enable | st_q.small_accum_enable[2];
        accum_live[3] = st_q.accum_a_enable | st_q.small_accum_enable[3];

        // Cascaded pairs take their input from one pin and ripple the carry upward.
        b_carry = pin_rise[0] & (st_q.accum[0] == pam_pkg::BYTE_MAX);
        a_carry = pin_rise[7] & (st_q.accum[2] == pam_pkg::BYTE_MAX);
        accum_inc[0] = pin_rise[0];
        accum_inc[1] = st_q.accum_b_enable ? b_carry : pin_rise[1];
        accum_inc[2] = st_q.accum_a_enable ? pin_rise[7] : pin_rise[2];
        accum_inc[3] = st_q.accum_a_enable ? a_carry : pin_rise[3];
        accum_inc    = accum_inc & accum_live & {4{accum_run}};
        for (int i = 0; i < 4; i++) begin
            if (accum_inc[i]) begin
                st_d.accum[i] = st_q.accum[i] + 8'h01;
            end
        end
        b_wrap = accum_inc[1] & (st_q.accum[1] == pam_pkg::BYTE_MAX);

        // Modulus down-counter prescaler produces a one-cycle tick.
        mod_tick = 1'b0;
        if (timer_run && st_q.modulus_run_enable) begin
            if (st_q.prescale == PRESCALE_LAST) begin
                st_d.prescale = pam_pkg::RST_BYTE;
                mod_tick      = 1'b1;
            end else begin
                st_d.prescale = st_q.prescale + 8'h01;
            end
        end

        latch_evt = 1'b0;
        if (mod_tick) begin
            if (st_q.mod_count == pam_pkg::WORD_ONE) begin
                st_d.mod_count         = pam_pkg::WORD_ZERO;
                st_d.modulus_zero_flag = 1'b1;
                latch_evt              = 1'b1;
            end else if (st_q.mod_count != pam_pkg::WORD_ZERO) begin
                st_d.mod_count = st_q.mod_count - pam_pkg::WORD_ONE;
            end else if (st_q.modulus_reload_mode) begin
                st_d.mod_count = st_q.mod_load;
            end
        end

        // Register writes.
        wr_zero_mod = reg_wr && reg_addr == pam_pkg::OFS_MODULUS_COUNT && reg_wdata == pam_pkg::WORD_ZERO;
        b_access    = (reg_wr || reg_rd)
                    && (reg_addr == pam_pkg::OFS_ACCUM_B_HIGH_BYTE || reg_addr == pam_pkg::OFS_ACCUM_B_LOW_BYTE);
        if (reg_wr) begin
            unique case (reg_addr)
                pam_pkg::OFS_TIMER_PORT_DIRECTION: st_d.pin_direction_bits = reg_wdata[7:0];
                pam_pkg::OFS_ACCUM_B_CONTROL: begin
                    st_d.accum_b_enable              = reg_wdata[pam_pkg::BIT_ACCUM_B_ENABLE];
                    st_d.accum_b_overflow_irq_enable = reg_wdata[pam_pkg::BIT_ACCUM_B_OVF_IRQ_EN];
                end
                pam_pkg::OFS_ACCUM_B_FLAGS: begin
                    if (reg_wdata[pam_pkg::BIT_ACCUM_B_OVF_FLAG]) begin
                        st_d.accum_b_overflow_flag = 1'b0;
                    end
                end
                pam_pkg::OFS_ACCUM3_HOLD: st_d.accum_hold[3] = reg_wdata[7:0];
                pam_pkg::OFS_ACCUM2_HOLD: st_d.accum_hold[2] = reg_wdata[7:0];
                pam_pkg::OFS_ACCUM1_HOLD: st_d.accum_hold[1] = reg_wdata[7:0];
                pam_pkg::OFS_ACCUM0_HOLD: st_d.accum_hold[0] = reg_wdata[7:0];
                pam_pkg::OFS_MODULUS_COUNT: begin
                    // A whole-word write is the only form; byte writes do not exist on this port.
                    if (reg_wdata == pam_pkg::WORD_ZERO) begin
                        st_d.mod_count         = pam_pkg::WORD_ZERO;
                        st_d.mod_load          = pam_pkg::WORD_ZERO;
                        st_d.modulus_zero_flag = st_q.modulus_zero_flag;
                    end else if (st_q.modulus_reload_mode) begin
                        st_d.mod_load = reg_wdata;
                    end else begin
                        st_d.prescale  = pam_pkg::RST_BYTE;
                        st_d.mod_load  = reg_wdata;
                        st_d.mod_count = reg_wdata;
                    end
                end
                pam_pkg::OFS_ACCUM_B_HIGH_BYTE: st_d.accum[1] = reg_wdata[7:0];
                pam_pkg::OFS_ACCUM_B_LOW_BYTE:  st_d.accum[0] = reg_wdata[7:0];
                pam_pkg::OFS_ACCUM3_COUNT:      st_d.accum[3] = reg_wdata[7:0];
                pam_pkg::OFS_ACCUM2_COUNT:      st_d.accum[2] = reg_wdata[7:0];
                pam_pkg::OFS_TIMER_SYSTEM_CONTROL: st_d.timer_system_control = reg_wdata[7:0];
                pam_pkg::OFS_MODULUS_CONTROL: begin
                    st_d.modulus_run_enable  = reg_wdata[pam_pkg::BIT_MODULUS_RUN_ENABLE];
                    st_d.modulus_reload_mode = reg_wdata[pam_pkg::BIT_MODULUS_RELOAD_MODE];
                    st_d.read_load_select    = reg_wdata[pam_pkg::BIT_READ_LOAD_SELECT];
                    if (reg_wdata[pam_pkg::BIT_FORCE_LOAD] && st_q.modulus_reload_mode) begin
                        st_d.mod_count = st_q.mod_load;
                    end
                    if (reg_wdata[pam_pkg::BIT_MODULUS_ZERO_FLAG] && !st_d.modulus_zero_flag) begin
                        st_d.modulus_zero_flag = 1'b0;
                    end else if (reg_wdata[pam_pkg::BIT_MODULUS_ZERO_FLAG] && !(mod_tick && latch_evt)) begin
                        st_d.modulus_zero_flag = 1'b0;
                    end
                end
                pam_pkg::OFS_CAPTURE_SYSTEM_CONTROL: begin
                    st_d.latch_mode_select     = reg_wdata[pam_pkg::BIT_LATCH_MODE_SELECT];
                    st_d.holding_buffer_enable = reg_wdata[pam_pkg::BIT_HOLDING_BUFFER_EN];
                    st_d.accum_a_enable        = reg_wdata[pam_pkg::BIT_ACCUM_A_ENABLE];
                end
                pam_pkg::OFS_SMALL_ACCUM_ENABLE_REG: st_d.small_accum_enable = reg_wdata[3:0];
                default: ; // Capture holds ignore writes; other indices are unmapped.
            endcase
        end

        // Latching needs latch mode and the holding buffers both on.
        latch_evt = (latch_evt || wr_zero_mod) && st_q.latch_mode_select && st_q.holding_buffer_enable;
        if (latch_evt) begin
            st_d.capture_hold = capture_registers;
            for (int i = 0; i < 4; i++) begin
                if (accum_live[i]) begin
                    st_d.accum_hold[i] = st_q.accum[i];
                end
                st_d.accum[i] = pam_pkg::RST_BYTE;
            end
        end

        // Flag clears come first so that an overflow in the same cycle wins.
        if (b_access && st_q.timer_system_control[pam_pkg::BIT_FAST_FLAG_CLEAR]) begin
            st_d.accum_b_overflow_flag = 1'b0;
        end
        if (b_wrap) begin
            st_d.accum_b_overflow_flag = 1'b1;
        end

        // Read data stands only in the cycle after the strobe.
        st_d.rdata = pam_pkg::RST_WORD;
        if (reg_rd) begin
            unique case (reg_addr)
                pam_pkg::OFS_TIMER_PORT_DIRECTION: st_d.rdata = {8'h00, st_q.pin_direction_bits};
                pam_pkg::OFS_ACCUM_B_CONTROL:
                    st_d.rdata = {14'h0000, st_q.accum_b_overflow_irq_enable, st_q.accum_b_enable};
                pam_pkg::OFS_ACCUM_B_FLAGS: st_d.rdata = {14'h0000, st_q.accum_b_overflow_flag, 1'b0};
                pam_pkg::OFS_ACCUM3_HOLD:   st_d.rdata = {8'h00, st_q.accum_hold[3]};
                pam_pkg::OFS_ACCUM2_HOLD:   st_d.rdata = {8'h00, st_q.accum_hold[2]};
                pam_pkg::OFS_ACCUM1_HOLD:   st_d.rdata = {8'h00, st_q.accum_hold[1]};
                pam_pkg::OFS_ACCUM0_HOLD:   st_d.rdata = {8'h00, st_q.accum_hold[0]};
                pam_pkg::OFS_MODULUS_COUNT:
                    st_d.rdata = st_q.read_load_select ? st_q.mod_load : st_q.mod_count;
                5'h08, 5'h09, 5'h0A, pam_pkg::OFS_CAPTURE3_HOLD:
                    st_d.rdata = st_q.capture_hold[reg_addr[1:0]];
                pam_pkg::OFS_ACCUM_B_HIGH_BYTE: st_d.rdata = {8'h00, st_q.accum[1]};
                pam_pkg::OFS_ACCUM_B_LOW_BYTE:  st_d.rdata = {8'h00, st_q.accum[0]};
                pam_pkg::OFS_ACCUM3_COUNT:      st_d.rdata = {8'h00, st_q.accum[3]};
                pam_pkg::OFS_ACCUM2_COUNT:      st_d.rdata = {8'h00, st_q.accum[2]};
                pam_pkg::OFS_TIMER_SYSTEM_CONTROL: st_d.rdata = {8'h00, st_q.timer_system_control};
                pam_pkg::OFS_MODULUS_CONTROL:
                    st_d.rdata = {8'h00, st_q.modulus_zero_flag, 4'h0, st_q.read_load_select,
                                  st_q.modulus_reload_mode, st_q.modulus_run_enable};
                pam_pkg::OFS_CAPTURE_SYSTEM_CONTROL:
                    st_d.rdata = {13'h0000, st_q.accum_a_enable, st_q.holding_buffer_enable,
                                  st_q.latch_mode_select};
                pam_pkg::OFS_SMALL_ACCUM_ENABLE_REG: st_d.rdata = {12'h000, st_q.small_accum_enable};
                default: st_d.rdata = pam_pkg::RST_WORD;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata         = st_q.rdata;
    assign pin_oe            = st_q.pin_direction_bits | oc_enable;
    assign accum_b_irq       = st_q.accum_b_overflow_flag & st_q.accum_b_overflow_irq_enable;
    assign modulus_zero_flag = st_q.modulus_zero_flag;

endmodule // pam_port_accum

// [verif/pam_pin_drv.sv]
// Model of the pulse sources that drive the timer port pins.
`timescale 1ns/1ps
module pam_pin_drv (
    input  wire logic       core_clk,
    output logic      [7:0] pin_in
);
    initial pin_in = 8'h00;
    // Four clocks high and at least four low keeps every pulse above the synchroniser's minimum width.
    task automatic send(input int ch, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            pin_in[ch] <= 1'b1;
            repeat (4) @(posedge core_clk);
            pin_in[ch] <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
        repeat (6) @(posedge core_clk);
    endtask
endmodule // pam_pin_drv

// [verif/pam_port_accum_chk.sv]
// Checker of the port behaviour of the pulse accumulator block.
`timescale 1ns/1ps
module pam_port_accum_chk #(
    parameter int unsigned PRESCALE = 4
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  oc_enable,
    input wire logic        stop_mode,
    input wire logic [7:0]  pin_oe,
    input wire logic        accum_b_irq,
    input wire logic        modulus_zero_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Shadows of the control bits that the outputs depend on, taken from the register writes.
    logic [7:0] dir_q;
    logic       ie_q;
    logic       ffc_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_q <= 8'h00;
            ie_q  <= 1'b0;
            ffc_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == pam_pkg::OFS_TIMER_PORT_DIRECTION) dir_q <= reg_wdata[7:0];
            if (reg_addr == pam_pkg::OFS_ACCUM_B_CONTROL) ie_q <= reg_wdata[1];
            if (reg_addr == pam_pkg::OFS_TIMER_SYSTEM_CONTROL) ffc_q <= reg_wdata[4];
        end
    end
    wire flag_wr = reg_wr && reg_addr == pam_pkg::OFS_ACCUM_B_FLAGS;
    wire cnt_acc = (reg_wr || reg_rd) && (reg_addr == pam_pkg::OFS_ACCUM_B_HIGH_BYTE
                   || reg_addr == pam_pkg::OFS_ACCUM_B_LOW_BYTE);
    property p_oc_force; (pin_oe & oc_enable) == oc_enable; endproperty
    a_oc_force: assert property (p_oc_force) else $error("pin_oe misses an enabled compare");
    property p_dir; pin_oe == (dir_q | oc_enable); endproperty
    a_dir: assert property (p_dir) else $error("pin_oe differs from direction bits");
    property p_irq_gate; accum_b_irq |-> ie_q; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq raised while disabled");
    property p_flag_clr; flag_wr && reg_wdata[1] |=> !accum_b_irq; endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag write did not clear");
    property p_flag_keep; flag_wr && !reg_wdata[1] && accum_b_irq |=> accum_b_irq; endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("zero write cleared flag");
    property p_fast_clr; cnt_acc && ffc_q |=> !accum_b_irq; endproperty
    a_fast_clr: assert property (p_fast_clr) else $error("fast clear missed");
    property p_zero_wr;
        reg_wr && reg_addr == pam_pkg::OFS_MODULUS_COUNT && reg_wdata == 16'h0000 && !modulus_zero_flag
        |=> !modulus_zero_flag [*4];
    endproperty
    a_zero_wr: assert property (p_zero_wr) else $error("zero write set zero flag");
    property p_stop; $past(stop_mode) |-> !$rose(modulus_zero_flag); endproperty
    a_stop: assert property (p_stop) else $error("counter ran in stop mode");
endmodule // pam_port_accum_chk
bind pam_port_accum pam_port_accum_chk #(.PRESCALE(PRESCALE)) pam_port_accum_chk_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .oc_enable(oc_enable), .stop_mode(stop_mode), .pin_oe(pin_oe),
    .accum_b_irq(accum_b_irq), .modulus_zero_flag(modulus_zero_flag));

// [verif/tb.sv]
// Self-checking testbench of the pulse accumulator block.
`timescale 1ns/1ps
module tb;
    logic              core_clk = 1'b0;
    logic              rst_n = 1'b0;
    pam_pkg::pam_req_s req = '0;
    logic [15:0]       rdata;
    logic [7:0]        pin_in;
    logic [7:0]        oc_en = 8'h00;
    logic [3:0][15:0]  caps = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
    logic              stop = 1'b0;
    logic              dbg = 1'b0;
    logic              wt = 1'b0;
    logic [7:0]        pin_oe;
    logic              irq;
    logic              zf;
    logic [15:0]       v;
    logic [15:0]       w;
    int                num_errors = 0;
    int                tests_run = 0;
    pam_port_accum #(.PRESCALE(2)) pam_port_accum_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(req.addr),
        .reg_wdata(req.wdata), .reg_wr(req.wr), .reg_rd(req.rd), .reg_rdata(rdata), .pin_in(pin_in),
        .oc_enable(oc_en), .capture_registers(caps), .stop_mode(stop), .debug_mode_state(dbg),
        .wait_mode(wt), .pin_oe(pin_oe), .accum_b_irq(irq), .modulus_zero_flag(zf));
    pam_pin_drv pam_pin_drv_i (.core_clk(core_clk), .pin_in(pin_in));
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask
    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_dir();
        wr(pam_pkg::OFS_TIMER_PORT_DIRECTION, 16'h00A5);
        oc_en <= 8'h0F;
        @(negedge core_clk);
        cmp("pin_oe", 16'h00AF, 16'(pin_oe));
        rd(pam_pkg::OFS_TIMER_PORT_DIRECTION, v);
        cmp("direction", 16'h00A5, v);
        @(posedge core_clk);
        oc_en <= 8'h00;
        @(negedge core_clk);
        cmp("pin_oe", 16'h00A5, 16'(pin_oe));
    endtask
    task automatic t_casc();
        wr(pam_pkg::OFS_SMALL_ACCUM_ENABLE_REG, 16'h0003);
        wr(pam_pkg::OFS_ACCUM_B_CONTROL, 16'h0001);
        pam_pin_drv_i.send(0, 5);
        pam_pin_drv_i.send(1, 2);
        rd(pam_pkg::OFS_ACCUM_B_LOW_BYTE, v);
        cmp("low byte", 16'h0005, v);
        rd(pam_pkg::OFS_ACCUM_B_HIGH_BYTE, v);
        cmp("high byte", 16'h0000, v);
        // Accumulator A cascades two and three from pin seven; the small enables are off for both.
        wr(pam_pkg::OFS_CAPTURE_SYSTEM_CONTROL, 16'h0004);
        pam_pin_drv_i.send(7, 3);
        rd(pam_pkg::OFS_ACCUM2_COUNT, v);
        cmp("accum A low", 16'h0003, v);
        rd(pam_pkg::OFS_ACCUM3_COUNT, v);
        cmp("accum A high", 16'h0000, v);
        wr(pam_pkg::OFS_CAPTURE_SYSTEM_CONTROL, 16'h0000);
        pam_pin_drv_i.send(7, 2);
        rd(pam_pkg::OFS_ACCUM2_COUNT, v);
        cmp("accum A off", 16'h0003, v);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge core_clk);
        cmp("irq", 16'(e), 16'(irq));
    endtask
    task automatic t_ovf();
        wr(pam_pkg::OFS_ACCUM_B_CONTROL, 16'h0002);
        pam_pin_drv_i.send(1, 256);
        chk_irq(1'b1);
        wr(pam_pkg::OFS_ACCUM_B_FLAGS, 16'h0000);
        chk_irq(1'b1);
        wr(pam_pkg::OFS_ACCUM_B_CONTROL, 16'h0000);
        chk_irq(1'b0);
        wr(pam_pkg::OFS_ACCUM_B_CONTROL, 16'h0002);
        chk_irq(1'b1);
        wr(pam_pkg::OFS_ACCUM_B_FLAGS, 16'h0002);
        chk_irq(1'b0);
        wr(pam_pkg::OFS_TIMER_SYSTEM_CONTROL, 16'h0010);
        pam_pin_drv_i.send(1, 256);
        chk_irq(1'b1);
        rd(pam_pkg::OFS_ACCUM_B_HIGH_BYTE, v);
        cmp("irq", 16'h0000, 16'(irq));
    endtask
    task automatic t_latch();
        wr(pam_pkg::OFS_TIMER_SYSTEM_CONTROL, 16'h0080);
        wr(pam_pkg::OFS_CAPTURE_SYSTEM_CONTROL, 16'h0003);
        wr(pam_pkg::OFS_SMALL_ACCUM_ENABLE_REG, 16'h000A);
        pam_pin_drv_i.send(3, 3);
        wr(pam_pkg::OFS_MODULUS_COUNT, 16'h0000);
        rd(pam_pkg::OFS_ACCUM3_HOLD, v);
        cmp("accum3 hold", 16'h0003, v);
        rd(pam_pkg::OFS_ACCUM3_COUNT, v);
        cmp("accum3 count", 16'h0000, v);
        rd(pam_pkg::OFS_CAPTURE3_HOLD, v);
        cmp("capture3 hold", 16'h4444, v);
        wr(pam_pkg::OFS_CAPTURE0_HOLD, 16'hBEEF);
        rd(pam_pkg::OFS_CAPTURE0_HOLD, v);
        cmp("capture0 hold", 16'h1111, v);
        cmp("zero flag", 16'h0000, 16'(zf));
    endtask
    task automatic hold_chk(input logic same);
        rd(pam_pkg::OFS_MODULUS_COUNT, v);
        repeat (8) @(posedge core_clk);
        rd(pam_pkg::OFS_MODULUS_COUNT, w);
        cmp("count frozen", 16'(same), 16'(v === w));
    endtask
    task automatic t_mod();
        int i;
        wr(pam_pkg::OFS_MODULUS_CONTROL, 16'h0001);
        wr(pam_pkg::OFS_MODULUS_COUNT, 16'h0005);
        for (i = 0; i < 40 && zf !== 1'b1; i++) @(negedge core_clk);
        cmp("ticks to zero", 16'h0001, 16'(i >= 8 && i <= 13));
        rd(pam_pkg::OFS_MODULUS_COUNT, v);
        cmp("count", 16'h0000, v);
        wr(pam_pkg::OFS_MODULUS_CONTROL, 16'h0083);
        wr(pam_pkg::OFS_MODULUS_COUNT, 16'h0100);
        for (int k = 0; k < 4; k++) begin
            stop <= (k == 0);
            wt <= (k == 1);
            dbg <= (k == 2);
            wr(pam_pkg::OFS_TIMER_SYSTEM_CONTROL, k == 1 ? 16'h00C0 : (k == 2 ? 16'h00A0 : 16'h0080));
            wr(pam_pkg::OFS_MODULUS_CONTROL, k == 3 ? 16'h0002 : 16'h0003);
            hold_chk(1'b1);
        end
        wt <= 1'b1;
        dbg <= 1'b1;
        wr(pam_pkg::OFS_MODULUS_CONTROL, 16'h0003);
        hold_chk(1'b0);
        wr(pam_pkg::OFS_MODULUS_COUNT, 16'h0010);
        rd(pam_pkg::OFS_MODULUS_COUNT, v);
        cmp("count kept", 16'h0001, 16'(v > 16'h0010));
        wr(pam_pkg::OFS_MODULUS_CONTROL, 16'h0007);
        rd(pam_pkg::OFS_MODULUS_COUNT, v);
        cmp("load", 16'h0010, v);
        wr(pam_pkg::OFS_MODULUS_CONTROL, 16'h000B);
        rd(pam_pkg::OFS_MODULUS_COUNT, v);
        cmp("forced", 16'h0001, 16'(v <= 16'h0010 && v >= 16'h000C));
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_dir();
        t_casc();
        t_ovf();
        t_latch();
        t_mod();
        wrap_up();
    end
    initial begin
        #(40 * 20000);
        num_errors++;
        wrap_up();
    end
endmodule // tb
